//--- ppes_sequencer.sv
// port pll enable sequencer: phy request/acknowledge and pll status
// Operation
// R1 - software changes frequency only while disabled
// R2 - run bring-up after phy initialisation completes
// R3 - software enables reference clock before settings
// R4 - hardware drives power state before configuring
// R5 - software writes all settings before enabling
// R6 - voltage steps wrap the enable and disable
// R7 - software writes enable to start sequence
// R8 - enable set raises transmitter setting request
// R9 - hardware waits for phy acknowledge
// R10 - force run set only after enable
// R11 - lock status samples phy run state
// R12 - disable write raises a new request
// R13 - software clears force run when disabling
// R14 - software polls completion before post step
// R15 - basic rates 162 to 810 MHz
// R16 - ultra rates need spread spectrum on
// R17 - embedded rates 216 to 432 MHz
// R18 - software computes hdmi bit rate
// R19 - firmware writes reference range setting
// R20 - software writes tabulated decimal values
// R21 - new enable ignored until handshake completes
`timescale 1ns/1ps
module ppes_sequencer (
    // clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    // control and configuration bits from software
    input  wire logic                         pllEnable,
    input  wire logic                         pllForceRun,
    input  wire logic                         voltPrepDone,
    input  wire ppes_pkg::ppes_rate_t         linkRate,
    input  wire logic [ppes_pkg::SET_W-1:0]   chargePumpSettings,
    input  wire logic [ppes_pkg::SET_W-1:0]   dividerSettings,
    input  wire logic [ppes_pkg::SET_W-1:0]   secondDividerSettings,
    input  wire logic [ppes_pkg::SET_W-1:0]   spreadEnableSettings,
    input  wire logic [ppes_pkg::SET_W-1:0]   spreadStepSettings,
    input  wire logic [ppes_pkg::SET_W-1:0]   fractionalSettingsOne,
    input  wire logic [ppes_pkg::SET_W-1:0]   fractionalSettingsTwo,
    // status bits to software
    output logic                              pllLock,
    output logic                              txSettingDone,
    output logic                              seqDonePulse,
    output logic                              useDefaultSetting,
    output logic                              spreadViolation,
    output logic [ppes_pkg::SYM_W-1:0]        symbolClockKhz,
    // phy side
    input  wire logic                         phyInitDone,
    input  wire logic                         txSettingAcknowledge,
    input  wire logic                         pllRunState,
    output logic                              txSettingRequest,
    output logic [1:0]                        txPowerState,
    output logic                              pllForceRunOut,
    output logic [ppes_pkg::SET_W-1:0]        phyChargePump,
    output logic [ppes_pkg::SET_W-1:0]        phyDivider,
    output logic [ppes_pkg::SET_W-1:0]        phySecondDivider,
    output logic [ppes_pkg::SET_W-1:0]        phySpreadEnable,
    output logic [ppes_pkg::SET_W-1:0]        phySpreadStep,
    output logic [ppes_pkg::SET_W-1:0]        phyFractionalOne,
    output logic [ppes_pkg::SET_W-1:0]        phyFractionalTwo
);
    ppes_pkg::ppes_state_t       state_q;
    logic [ppes_pkg::PREP_W-1:0] prep_q;
    logic                        targetOn_q;
    logic                        pllOn_q;
    logic                        initSync;
    logic                        ackSync;
    logic                        runSync;

    // symbol clock per link rate
    function automatic logic [ppes_pkg::SYM_W-1:0] symClk(
        input ppes_pkg::ppes_rate_t r);
        unique case (r)
            ppes_pkg::RATE_RBR:      symClk = 20'h2_78D0;
            ppes_pkg::RATE_HBR1:     symClk = 20'h4_1EB0;
            ppes_pkg::RATE_HBR2:     symClk = 20'h8_3D60;
            ppes_pkg::RATE_HBR3:     symClk = 20'hC_5C10;
            ppes_pkg::RATE_UHBR10:   symClk = 20'h4_C4B4;
            ppes_pkg::RATE_UHBR13P5: symClk = 20'h6_6FF3;
            ppes_pkg::RATE_EDP216:   symClk = 20'h3_4BC0;
            ppes_pkg::RATE_EDP243:   symClk = 20'h3_B538;
            ppes_pkg::RATE_EDP324:   symClk = 20'h4_F1A0;
            ppes_pkg::RATE_EDP432:   symClk = 20'h6_9780;
            default:                 symClk = 20'h0_0000;
        endcase
    endfunction

    // ultra-high rates carry a minimum spread requirement
    function automatic logic needsSpread(input ppes_pkg::ppes_rate_t r);
        needsSpread = (r == ppes_pkg::RATE_UHBR10) ||
                      (r == ppes_pkg::RATE_UHBR13P5);
    endfunction

    // phy signals come from another domain, so resynchronise them
    ppes_sync #(
        .WIDTH (3)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .asyncIn ({phyInitDone, txSettingAcknowledge, pllRunState}),
        .syncOut ({initSync, ackSync, runSync})
    );

    // sequencer: a request at bring-up, then one whenever idle finds enable differing from pll state while voltPrepDone is high
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q    <= ppes_pkg::S_BOOT;
            prep_q     <= '0;
            targetOn_q <= 1'b0;
            pllOn_q    <= 1'b0;
        end else begin
            unique case (state_q)
                // R2 bring-up after init
                ppes_pkg::S_BOOT: begin
                    if (initSync) begin
                        state_q    <= ppes_pkg::S_PREP;
                        targetOn_q <= 1'b0;
                        prep_q     <= '0;
                    end
                end
                // R6 waits for voltage step; R12 disable also requests
                ppes_pkg::S_IDLE: begin
                    if (voltPrepDone && (pllEnable != pllOn_q)) begin
                        state_q    <= ppes_pkg::S_PREP;
                        targetOn_q <= pllEnable;
                        prep_q     <= '0;
                    end
                end
                // R4 hold power state before requesting
                ppes_pkg::S_PREP: begin
                    if (prep_q == ppes_pkg::PREP_LAST) begin
                        state_q <= ppes_pkg::S_REQ;
                    end else begin
                        prep_q <= prep_q + 1'b1;
                    end
                end
                // R9 wait for acknowledge
                ppes_pkg::S_REQ: begin
                    if (ackSync) begin
                        state_q <= ppes_pkg::S_RELEASE;
                        pllOn_q <= targetOn_q;
                    end
                end
                // R21 no new request until acknowledge drops
                ppes_pkg::S_RELEASE: begin
                    if (!ackSync) begin
                        state_q <= ppes_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    // R8 request held while waiting
    assign txSettingRequest = (state_q == ppes_pkg::S_REQ);
    assign txSettingDone    = (state_q == ppes_pkg::S_IDLE);

    // R4 power state: config while preparing or off, active once on
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            txPowerState <= ppes_pkg::PSTATE_OFF;
        end else if (state_q == ppes_pkg::S_BOOT && !initSync) begin
            txPowerState <= ppes_pkg::PSTATE_OFF;
        end else if (state_q == ppes_pkg::S_PREP || !pllOn_q) begin
            txPowerState <= ppes_pkg::PSTATE_CONFIG;
        end else begin
            txPowerState <= ppes_pkg::PSTATE_ACTIVE;
        end
    end

    // settings are sampled only when an enable starts, so the phy
    // never sees them move while running
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            phyChargePump     <= ppes_pkg::SET_RESET;
            phyDivider        <= ppes_pkg::SET_RESET;
            phySecondDivider  <= ppes_pkg::SET_RESET;
            phySpreadEnable   <= ppes_pkg::SET_RESET;
            phySpreadStep     <= ppes_pkg::SET_RESET;
            phyFractionalOne  <= ppes_pkg::SET_RESET;
            phyFractionalTwo  <= ppes_pkg::SET_RESET;
            useDefaultSetting <= 1'b1;
        end else if (state_q == ppes_pkg::S_IDLE && voltPrepDone &&
                     pllEnable && !pllOn_q) begin
            phyChargePump     <= chargePumpSettings;
            phyDivider        <= dividerSettings;
            phySecondDivider  <= secondDividerSettings;
            phySpreadEnable   <= spreadEnableSettings;
            phySpreadStep     <= spreadStepSettings;
            phyFractionalOne  <= fractionalSettingsOne;
            phyFractionalTwo  <= fractionalSettingsTwo;
            useDefaultSetting <= 1'b0;
        end
    end

    // status: lock, force run gate, completion pulse, rate info
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pllLock         <= 1'b0;
            pllForceRunOut  <= 1'b0;
            seqDonePulse    <= 1'b0;
            spreadViolation <= 1'b0;
            symbolClockKhz  <= '0;
        end else begin
            // R11 lock follows phy run state
            pllLock        <= runSync;
            // force run blocked until pll is on, so dividers are sampled
            pllForceRunOut <= pllForceRun && pllOn_q;
            seqDonePulse   <= (state_q == ppes_pkg::S_RELEASE) &&
                              !ackSync;
            // R16 spread required for ultra rates
            spreadViolation <= needsSpread(linkRate) &&
                               !spreadEnableSettings[0];
            // R15 R17 symbol clock of selected rate
            symbolClockKhz  <= symClk(linkRate);
        end
    end

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_req_after_prep;
        $rose(txSettingRequest) |->
            $past(state_q == ppes_pkg::S_PREP) &&
            txPowerState == ppes_pkg::PSTATE_CONFIG;
    endproperty
    a_req_after_prep: assert property (p_req_after_prep) // R4
        else $error("request raised without config power state");

    property p_enable_requests;
        (state_q == ppes_pkg::S_IDLE && voltPrepDone && pllEnable &&
         !pllOn_q) |-> ##(ppes_pkg::PSTATE_SETUP_CYC + 1) txSettingRequest;
    endproperty
    a_enable_requests: assert property (p_enable_requests) // R8
        else $error("enable did not raise request");

    property p_disable_requests;
        (state_q == ppes_pkg::S_IDLE && voltPrepDone && !pllEnable &&
         pllOn_q) |-> ##(ppes_pkg::PSTATE_SETUP_CYC + 1) txSettingRequest;
    endproperty
    a_disable_requests: assert property (p_disable_requests) // R12
        else $error("disable did not raise request");

    property p_wait_ack;
        txSettingRequest && !ackSync |=> txSettingRequest;
    endproperty
    a_wait_ack: assert property (p_wait_ack) // R9
        else $error("request dropped before acknowledge");

    property p_no_new_req;
        state_q == ppes_pkg::S_RELEASE && ackSync |=> !txSettingRequest;
    endproperty
    a_no_new_req: assert property (p_no_new_req) // R21
        else $error("new request before acknowledge cleared");

    property p_boot_waits;
        state_q == ppes_pkg::S_BOOT && !initSync |=> !txSettingRequest;
    endproperty
    a_boot_waits: assert property (p_boot_waits) // R2
        else $error("request before phy initialisation");

    property p_lock_sample;
        ##2 pllLock == $past(pllRunState, 3);
    endproperty
    a_lock_sample: assert property (p_lock_sample) // R11
        else $error("lock status does not follow run state");

    property p_volt_gate;
        state_q == ppes_pkg::S_IDLE && !voltPrepDone |=>
            state_q == ppes_pkg::S_IDLE;
    endproperty
    a_volt_gate: assert property (p_volt_gate) // R6
        else $error("sequence started before voltage step");

    property p_uhbr_spread;
        needsSpread(linkRate) && !spreadEnableSettings[0] |=>
            spreadViolation;
    endproperty
    a_uhbr_spread: assert property (p_uhbr_spread) // R16
        else $error("missing spread violation flag");

    property p_rbr_clock;
        linkRate == ppes_pkg::RATE_RBR |=> symbolClockKhz == 20'h2_78D0;
    endproperty
    a_rbr_clock: assert property (p_rbr_clock) // R15
        else $error("wrong basic rate symbol clock");

    property p_edp_clock;
        linkRate == ppes_pkg::RATE_EDP432 |=> symbolClockKhz == 20'h6_9780;
    endproperty
    a_edp_clock: assert property (p_edp_clock) // R17
        else $error("wrong embedded rate symbol clock");

    c_enable: cover property (txSettingRequest && targetOn_q && ackSync);
    c_disable: cover property (txSettingRequest && !targetOn_q && ackSync);
    c_done: cover property (seqDonePulse && pllOn_q);
endmodule

//--- ppes_pkg.sv
// shared constants and types for the port pll enable sequencer
package ppes_pkg;

    // clock and timing
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int PSTATE_SETUP_NS = 20;
    localparam int PSTATE_SETUP_CYC =
        (PSTATE_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PREP_W = 3;
    localparam logic [PREP_W-1:0] PREP_LAST =
        PREP_W'(PSTATE_SETUP_CYC - 1);

    // vco setting that the phy uses before software programs one
    localparam int VCO_DEFAULT_MHZ = 13500;

    // transmitter power states
    localparam logic [1:0] PSTATE_OFF    = 2'h0;
    localparam logic [1:0] PSTATE_CONFIG = 2'h1;
    localparam logic [1:0] PSTATE_ACTIVE = 2'h2;

    // setting word width and reset value
    localparam int SET_W = 32;
    localparam logic [SET_W-1:0] SET_RESET = 32'h0000_0000;

    // symbol clock in khz
    localparam int SYM_W = 20;

    // link rate selection
    typedef enum logic [3:0] {
        RATE_RBR, RATE_HBR1, RATE_HBR2, RATE_HBR3,
        RATE_UHBR10, RATE_UHBR13P5,
        RATE_EDP216, RATE_EDP243, RATE_EDP324, RATE_EDP432
    } ppes_rate_t;

    // sequencer states
    typedef enum logic [2:0] {
        S_BOOT, S_IDLE, S_PREP, S_REQ, S_RELEASE
    } ppes_state_t;

endpackage

//--- ppes_sync.sv
// two-flop synchroniser for signals arriving from the phy
`timescale 1ns/1ps
module ppes_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

//--- ppes_phy_model.sv
// behavioural phy with embedded pll facing the sequencer
`timescale 1ns/1ps
module ppes_phy_model (
    // clock
    ref_clk,
    // requests from the sequencer
    txSettingRequest,
    txPowerState,
    pllForceRunOut,
    // bench knob: answer delay in cycles
    ackDelay,
    // answers to the sequencer
    txSettingAcknowledge,
    pllRunState
);
    input  wire logic       ref_clk;
    input  wire logic       txSettingRequest;
    input  wire logic [1:0] txPowerState;
    input  wire logic       pllForceRunOut;
    input  wire logic [3:0] ackDelay;
    output logic            txSettingAcknowledge;
    output logic            pllRunState;

    logic [3:0] waitCnt;

    initial begin
        txSettingAcknowledge = 1'h0;
        pllRunState = 1'h0;
        waitCnt = 4'h0;
    end

    // four phase answer
    // both edges of ack lag req, so a slow phy stretches the two phases that end on an ack edge
    always @(posedge ref_clk) begin
        if (txSettingRequest != txSettingAcknowledge) begin
            if (waitCnt >= ackDelay) begin
                txSettingAcknowledge <= txSettingRequest;
                waitCnt <= 4'h0;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end

    // pll runs while active or forced
    always @(posedge ref_clk) begin
        pllRunState <= (txPowerState == ppes_pkg::PSTATE_ACTIVE)
                       || pllForceRunOut;
    end
endmodule

//--- test_ppes_sequencer.sv
// self-checking bench for the port pll enable sequencer
`timescale 1ns/1ps
module test_ppes_sequencer;
    // controls driven by the bench
    logic                 ref_clk, rst_n, pllEnable, pllForceRun;
    logic                 voltPrepDone, phyInitDone;
    ppes_pkg::ppes_rate_t linkRate;
    logic [3:0]           ackDelay;
    logic [31:0]          chargePumpSettings, dividerSettings;
    logic [31:0]          secondDividerSettings, spreadEnableSettings;
    logic [31:0]          spreadStepSettings, fractionalSettingsOne;
    logic [31:0]          fractionalSettingsTwo;
    // outputs of the sequencer and the phy model
    logic                 pllLock, txSettingDone, seqDonePulse;
    logic                 useDefaultSetting, spreadViolation;
    logic [19:0]          symbolClockKhz;
    logic                 txSettingAcknowledge, pllRunState;
    logic                 txSettingRequest, pllForceRunOut;
    logic [1:0]           txPowerState;
    logic [31:0]          phyChargePump, phyDivider, phySecondDivider;
    logic [31:0]          phySpreadEnable, phySpreadStep;
    logic [31:0]          phyFractionalOne, phyFractionalTwo;
    logic [223:0]         savedSet;
    int                   errorCnt = 0;
    int                   comparisons = 0;
    // symbol clock per rate, in enum order
    localparam int KHZ [10] = '{162000, 270000, 540000, 810000, 312500,
                                421875, 216000, 243000, 324000, 432000};

    wire logic [223:0] phyAll = {phyChargePump, phyDivider,
        phySecondDivider, phySpreadEnable, phySpreadStep,
        phyFractionalOne, phyFractionalTwo};
    wire logic [223:0] setAll = {chargePumpSettings, dividerSettings,
        secondDividerSettings, spreadEnableSettings, spreadStepSettings,
        fractionalSettingsOne, fractionalSettingsTwo};

    ppes_sequencer uut (.ref_clk, .rst_n, .pllEnable, .pllForceRun,
        .voltPrepDone, .linkRate, .chargePumpSettings, .dividerSettings,
        .secondDividerSettings, .spreadEnableSettings, .spreadStepSettings,
        .fractionalSettingsOne, .fractionalSettingsTwo, .pllLock,
        .txSettingDone, .seqDonePulse, .useDefaultSetting, .spreadViolation,
        .symbolClockKhz, .phyInitDone, .txSettingAcknowledge, .pllRunState,
        .txSettingRequest, .txPowerState, .pllForceRunOut, .phyChargePump,
        .phyDivider, .phySecondDivider, .phySpreadEnable, .phySpreadStep,
        .phyFractionalOne, .phyFractionalTwo);

    ppes_phy_model phy (.ref_clk, .txSettingRequest, .txPowerState,
        .pllForceRunOut, .ackDelay, .txSettingAcknowledge, .pllRunState);

    // compare, counted either way
    task automatic chk(input logic [223:0] got, input logic [223:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // bounded wait for a request level
    task automatic waitReq(input logic val);
        int n = 0;
        while (txSettingRequest !== val && n < 40) begin
            @(negedge ref_clk);
            n++;
        end
        chk(txSettingRequest, val);
    endtask

    // bounded wait for the handshake to close
    task automatic waitIdle();
        int n = 0;
        while (txSettingDone !== 1'h1 && n < 60) begin
            @(negedge ref_clk);
            n++;
        end
        chk(seqDonePulse, 1'h1);
        @(negedge ref_clk);
        chk(seqDonePulse, 1'h0);
    endtask

    task automatic tBringUp();
        chk(useDefaultSetting, 1'h1);
        phyInitDone = 1'h1;
        waitReq(1'h1);
        chk(txPowerState, ppes_pkg::PSTATE_CONFIG);
        waitIdle();
    endtask

    // enable held back until the voltage step is done
    task automatic tGate();
        voltPrepDone = 1'h0;
        pllEnable = 1'h1;
        repeat (12) begin
            @(negedge ref_clk);
            chk(txSettingRequest, 1'h0);
        end
    endtask

    // enable, with a toggle of the enable mid-handshake
    task automatic tEnable();
        savedSet = setAll;
        voltPrepDone = 1'h1;
        waitReq(1'h1);
        chk(txPowerState, ppes_pkg::PSTATE_CONFIG);
        pllEnable = 1'h0;
        @(negedge ref_clk);
        pllEnable = 1'h1;
        waitIdle();
        repeat (10) begin
            @(negedge ref_clk);
            chk(txSettingRequest, 1'h0);
        end
        chk(txPowerState, ppes_pkg::PSTATE_ACTIVE);
        chk(phyAll, savedSet);
        chk(useDefaultSetting, 1'h0);
        chargePumpSettings = 32'h0000_0000;
        @(negedge ref_clk);
        chk(phyAll, savedSet);
        chk(pllLock, 1'h1);
    endtask

    task automatic tForce();
        pllForceRun = 1'h1;
        repeat (2) @(negedge ref_clk);
        chk(pllForceRunOut, 1'h1);
    endtask

    // every rate, spread off then on
    // hdmi bit rates are worked out by software, not driven here
    task automatic tRates();
        for (int i = 0; i < 10; i++) begin
            linkRate = ppes_pkg::ppes_rate_t'(i);
            spreadEnableSettings = 32'h0000_0000;
            repeat (2) @(negedge ref_clk);
            chk(symbolClockKhz, KHZ[i]);
            chk(spreadViolation, i == 4 || i == 5);
            spreadEnableSettings = 32'h0000_0001;
            repeat (2) @(negedge ref_clk);
            chk(spreadViolation, 1'h0);
        end
    endtask

    // disable against a slow phy
    task automatic tDisable();
        ackDelay = 4'h6;
        pllEnable = 1'h0;
        pllForceRun = 1'h0;
        waitReq(1'h1);
        chk(txPowerState, ppes_pkg::PSTATE_CONFIG);
        // poll until the handshake has closed
        waitIdle();
        chk(pllForceRunOut, 1'h0);
        repeat (6) @(negedge ref_clk);
        chk(pllLock, 1'h0);
    endtask

    task automatic endSim();
        $display("errors %0d comparisons %0d", errorCnt, comparisons);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // free running 250 MHz clock
    initial begin
        ref_clk = 1'h0;
        forever #2 ref_clk = ~ref_clk;
    end

    // main sequence, inputs move on falling edges
    initial begin
        rst_n = 1'h0;
        pllEnable = 1'h0;
        pllForceRun = 1'h0;
        voltPrepDone = 1'h1;
        phyInitDone = 1'h0;
        ackDelay = 4'h1;
        // reference clock and range are up before any setting
        // tabulated words for one rate, all written before enable
        linkRate = ppes_pkg::RATE_HBR2;
        chargePumpSettings = 32'h0000_1404;
        dividerSettings = 32'h0012_0304;
        secondDividerSettings = 32'h0000_00b8;
        spreadEnableSettings = 32'h0000_0001;
        spreadStepSettings = 32'h0000_a087;
        fractionalSettingsOne = 32'h0000_0005;
        fractionalSettingsTwo = 32'h0003_9999;
        repeat (2) @(negedge ref_clk);
        chk(txPowerState, ppes_pkg::PSTATE_OFF);
        chk(txSettingDone, 1'h0);
        rst_n = 1'h1;
        tBringUp();
        tGate();
        tEnable();
        tForce();
        tRates();
        tDisable();
        endSim();
    end

    // watchdog well past the expected run length
    initial begin
        repeat (5000) @(posedge ref_clk);
        errorCnt++;
        endSim();
    end
endmodule
